/* shared/rtcc_pkg.sv */
`default_nettype none
package rtcc_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_SEC      = 4'h0;
  localparam logic [3:0] ADDR_MIN      = 4'h1;
  localparam logic [3:0] ADDR_HOUR     = 4'h2;
  localparam logic [3:0] ADDR_WDAY     = 4'h3;
  localparam logic [3:0] ADDR_DAY      = 4'h4;
  localparam logic [3:0] ADDR_MONTH    = 4'h5;
  localparam logic [3:0] ADDR_YEAR     = 4'h6;
  localparam logic [3:0] ADDR_ALA_MIN  = 4'h8;
  localparam logic [3:0] ADDR_ALA_HOUR = 4'h9;
  localparam logic [3:0] ADDR_ALA_WDAY = 4'hA;
  localparam logic [3:0] ADDR_ALB_MIN  = 4'hB;
  localparam logic [3:0] ADDR_ALB_HOUR = 4'hC;
  localparam logic [3:0] ADDR_ALB_WDAY = 4'hD;
  localparam logic [3:0] ADDR_CTRL1    = 4'hE;
  localparam logic [3:0] ADDR_CTRL2    = 4'hF;

  // ----------------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------------
  localparam int CTRL1_ALA_EN   = 7;
  localparam int CTRL1_ALB_EN   = 6;
  localparam int CTRL2_HOUR_FMT = 5;
  localparam int CTRL2_CLK_DIS  = 3;
  localparam int CTRL2_PER_FLAG = 2;
  localparam int CTRL2_ALA_FLAG = 1;
  localparam int CTRL2_ALB_FLAG = 0;

  // ----------------------------------------------------------------------
  // periodic interrupt selections
  // ----------------------------------------------------------------------
  localparam logic [2:0] PER_OFF      = 3'h0;
  localparam logic [2:0] PER_FIXED_LO = 3'h1;
  localparam logic [2:0] PER_SECOND   = 3'h4;
  localparam logic [2:0] PER_MINUTE   = 3'h5;
  localparam logic [2:0] PER_HOUR     = 3'h6;
  localparam logic [2:0] PER_MONTH    = 3'h7;

  // ----------------------------------------------------------------------
  // BCD limits and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] BCD_00   = 8'h00;
  localparam logic [7:0] BCD_01   = 8'h01;
  localparam logic [7:0] BCD_11   = 8'h11;
  localparam logic [7:0] BCD_12   = 8'h12;
  localparam logic [7:0] BCD_23   = 8'h23;
  localparam logic [7:0] BCD_28   = 8'h28;
  localparam logic [7:0] BCD_29   = 8'h29;
  localparam logic [7:0] BCD_30   = 8'h30;
  localparam logic [7:0] BCD_31   = 8'h31;
  localparam logic [7:0] BCD_59   = 8'h59;
  localparam logic [7:0] BCD_99   = 8'h99;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [7:0] RST_HOUR = 8'h12;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE  = 8'h01;

  // ----------------------------------------------------------------------
  // timing: crystal cycles per second count
  // ----------------------------------------------------------------------
  localparam int XTAL_HZ = 32768;
endpackage : rtcc_pkg
`default_nettype wire

/* src/rtcc_core.sv */
// Behaviour
// - clock output runs unless clock_out_disable set
// - periodic flag reads 1 while the periodic source holds the output low
// - level mode: write 0 clears periodic flag
// - alarm flag sets on match; enable gates
// - write 0 clears alarm flag, releases output
// - disabled alarm: no match, flag reads 0
// - seconds BCD 00..59, carry to minutes
// - minutes BCD 00..59, carry to hours
// - hour rollover carries to day and weekday
// - weekday counts 0..6 then wraps
// - day wrap carries into month
// - month BCD 1..12, carry into year
// - years multiple of four are leap
// - seconds/minutes at 0h/1h, bit7 zero
// - hours at 2h, bits 7:6 zero
// - weekday 3h, day 4h, month 5h layouts
// - hour format select 12 or 24 coding
// - level irq falls with seconds increment
`default_nettype none
module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int XTAL_DIV = rtcc_pkg::XTAL_HZ
)
(
  // system clock and reset
  input  wire  logic       clk_i,
  input  wire  logic       rst_i,
  // crystal clock domain
  input  wire  logic       xtal_clk_i,
  // register port from the serial bus front end
  input  wire  logic [3:0] reg_addr_i,
  input  wire  logic       reg_wr_i,
  input  wire  logic [7:0] reg_wdata_i,
  output var   logic [7:0] reg_rdata_o,
  // interrupt and clock outputs
  output var   logic       irq_out_a_n_o,
  output var   logic       irq_out_b_n_o,
  output var   logic       clk_out_o
);
  import rtcc_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // returns {wrapped, next}
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    logic [8:0] r;
    if (v == hi)
      r = {1'b1, lo};
    else if (v[3:0] == 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v + 8'h01};
    return r;
  endfunction : bcd_inc

  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    if (y[4] == 1'b0)
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    else
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    return r;
  endfunction : is_leap

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] r;
    r = BCD_31;
    if (m == 8'h02)
      r = is_leap(y) ? BCD_29 : BCD_28;
    else if ((m == 8'h04) || (m == 8'h06) || (m == 8'h09) || (m == 8'h11))
      r = BCD_30;
    return r;
  endfunction : month_len

  // one strobe per address; keeps the decode in one place
  function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] sel);
    return wr && (a == sel);
  endfunction : wr_hit

  // alarm match on the time that will stand after this edge
  function automatic logic alarm_hit(input logic [7:0] a_min, input logic [7:0] a_hour,
                                     input logic [6:0] a_wday, input logic [7:0] t_min,
                                     input logic [7:0] t_hour, input logic [2:0] t_wday);
    return (t_min == a_min) && (t_hour == a_hour) && a_wday[t_wday];
  endfunction : alarm_hit

  // ----------------------------------------------------------------------
  // crystal domain: second divider and clock output
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] div;
    logic        tick_tgl;
    logic        dis_s1;
    logic        dis_s2;
    logic        clk_out;
  } rtcc_xtal_s;

  rtcc_xtal_s x_q, x_d;
  logic       clk_dis_q;

  always_comb
  begin
    x_d = x_q;
    x_d.dis_s1 = clk_dis_q;
    x_d.dis_s2 = x_q.dis_s1;
    if (x_q.div == 16'(XTAL_DIV - 1))
    begin
      x_d.div      = '0;
      x_d.tick_tgl = ~x_q.tick_tgl;
    end
    else
      x_d.div = x_q.div + 16'h0001;
    // toggling flop gives half the crystal rate; a gated crystal would glitch
    x_d.clk_out = x_q.dis_s2 ? 1'b1 : ~x_q.clk_out;
  end

  always_ff @(posedge xtal_clk_i or posedge rst_i)
  begin
    if (rst_i)
      x_q <= '{div: '0, tick_tgl: 1'b0, dis_s1: 1'b0, dis_s2: 1'b0, clk_out: 1'b1};
    else
      x_q <= x_d;
  end

  assign clk_out_o = x_q.clk_out;

  // ----------------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] tgl_sync;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] ala_min;
    logic [7:0] ala_hour;
    logic [6:0] ala_wday;
    logic [7:0] alb_min;
    logic [7:0] alb_hour;
    logic [6:0] alb_wday;
    logic       ala_en;
    logic       alb_en;
    logic [2:0] per_sel;
    logic       fmt24;
    logic       clk_dis;
    logic       per_flag;
    logic       ala_flag;
    logic       alb_flag;
    logic [7:0] rdata;
    logic       irq_a_n;
    logic       irq_b_n;
  } rtcc_sys_s;

  rtcc_sys_s s_q, s_d;

  assign clk_dis_q     = s_q.clk_dis;
  assign reg_rdata_o   = s_q.rdata;
  assign irq_out_a_n_o = s_q.irq_a_n;
  assign irq_out_b_n_o = s_q.irq_b_n;

  logic       tick;
  logic [8:0] r_sec, r_min, r_hour24, r_day, r_mon, r_year;
  logic       c_sec, c_min, c_hour, c_day;
  logic [7:0] hour12;
  logic       per_hit, ala_hit, alb_hit, per_level, per_lo;
  logic       wr0, wr1, wr2, wr3, wr4, wr5, wr6, wr8, wr9, wra, wrb, wrc, wrd, wre, wrf;

  always_comb
  begin
    s_d = s_q;
    // --------------------------------------------------------------------
    // tick synchroniser: the second and third stages feed the edge detector
    // --------------------------------------------------------------------
    s_d.tgl_sync = {s_q.tgl_sync[1:0], x_q.tick_tgl};
    tick = s_q.tgl_sync[2] ^ s_q.tgl_sync[1];

    // --------------------------------------------------------------------
    // carry chain, all in the tick cycle
    // --------------------------------------------------------------------
    r_sec  = bcd_inc(s_q.sec, BCD_00, BCD_59);
    c_sec  = tick && r_sec[8];
    r_min  = bcd_inc(s_q.min, BCD_00, BCD_59);
    c_min  = c_sec && r_min[8];
    r_hour24 = bcd_inc(s_q.hour, BCD_00, BCD_23);
    hour12 = s_q.hour;
    if (s_q.hour[4:0] == BCD_11[4:0])
      hour12 = {2'b00, ~s_q.hour[5], BCD_12[4:0]};
    else if (s_q.hour[4:0] == BCD_12[4:0])
      hour12 = {2'b00, s_q.hour[5], BCD_01[4:0]};
    else
      hour12 = {2'b00, s_q.hour[5], 5'(bcd_inc({3'b000, s_q.hour[4:0]}, BCD_01, BCD_12))};
    c_hour = c_min && (s_q.fmt24 ? r_hour24[8] : (s_q.hour == {2'b00, 1'b1, BCD_11[4:0]}));
    r_day  = bcd_inc(s_q.day, BCD_01, month_len(s_q.month, s_q.year));
    c_day  = c_hour && r_day[8];
    r_mon  = bcd_inc(s_q.month, BCD_01, BCD_12);
    r_year = bcd_inc(s_q.year, BCD_00, BCD_99);

    // --------------------------------------------------------------------
    // counter updates
    // --------------------------------------------------------------------
    if (tick)
      s_d.sec = r_sec[7:0];
    if (c_sec)
      s_d.min = r_min[7:0];
    if (c_min)
      s_d.hour = s_q.fmt24 ? r_hour24[7:0] : hour12;
    if (c_hour)
    begin
      s_d.wday = (s_q.wday == WDAY_MAX) ? 3'h0 : s_q.wday + 3'h1;
      s_d.day  = r_day[7:0];
    end
    if (c_day)
      s_d.month = r_mon[7:0];
    if (c_day && r_mon[8])
      s_d.year = r_year[7:0];

    // --------------------------------------------------------------------
    // periodic level mode, set on the same tick as the seconds step
    // --------------------------------------------------------------------
    per_level = s_q.per_sel[2];
    unique case (s_q.per_sel)
      PER_SECOND: per_hit = tick;
      PER_MINUTE: per_hit = c_sec;
      PER_HOUR:   per_hit = c_min;
      PER_MONTH:  per_hit = c_day;
      default:    per_hit = 1'b0;
    endcase

    // --------------------------------------------------------------------
    // alarms compare the time just counted, at the start of each minute
    // --------------------------------------------------------------------
    ala_hit = c_sec && s_q.ala_en && alarm_hit(s_q.ala_min, s_q.ala_hour, s_q.ala_wday,
                                               s_d.min, s_d.hour, s_d.wday);
    alb_hit = c_sec && s_q.alb_en && alarm_hit(s_q.alb_min, s_q.alb_hour, s_q.alb_wday,
                                               s_d.min, s_d.hour, s_d.wday);

    // --------------------------------------------------------------------
    // register writes; a write to a counter beats the tick for that counter
    // --------------------------------------------------------------------
    wr0 = wr_hit(reg_wr_i, reg_addr_i, ADDR_SEC);
    wr1 = wr_hit(reg_wr_i, reg_addr_i, ADDR_MIN);
    wr2 = wr_hit(reg_wr_i, reg_addr_i, ADDR_HOUR);
    wr3 = wr_hit(reg_wr_i, reg_addr_i, ADDR_WDAY);
    wr4 = wr_hit(reg_wr_i, reg_addr_i, ADDR_DAY);
    wr5 = wr_hit(reg_wr_i, reg_addr_i, ADDR_MONTH);
    wr6 = wr_hit(reg_wr_i, reg_addr_i, ADDR_YEAR);
    wr8 = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALA_MIN);
    wr9 = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALA_HOUR);
    wra = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALA_WDAY);
    wrb = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALB_MIN);
    wrc = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALB_HOUR);
    wrd = wr_hit(reg_wr_i, reg_addr_i, ADDR_ALB_WDAY);
    wre = wr_hit(reg_wr_i, reg_addr_i, ADDR_CTRL1);
    wrf = wr_hit(reg_wr_i, reg_addr_i, ADDR_CTRL2);

    if (wr0)
      s_d.sec = {1'b0, reg_wdata_i[6:0]};
    if (wr1)
      s_d.min = {1'b0, reg_wdata_i[6:0]};
    if (wr2)
      s_d.hour = {2'b00, reg_wdata_i[5:0]};
    if (wr3)
      s_d.wday = reg_wdata_i[2:0];
    if (wr4)
      s_d.day = {2'b00, reg_wdata_i[5:0]};
    if (wr5)
      s_d.month = {3'b000, reg_wdata_i[4:0]};
    if (wr6)
      s_d.year = reg_wdata_i;
    if (wr8)
      s_d.ala_min = {1'b0, reg_wdata_i[6:0]};
    if (wr9)
      s_d.ala_hour = {2'b00, reg_wdata_i[5:0]};
    if (wra)
      s_d.ala_wday = reg_wdata_i[6:0];
    if (wrb)
      s_d.alb_min = {1'b0, reg_wdata_i[6:0]};
    if (wrc)
      s_d.alb_hour = {2'b00, reg_wdata_i[5:0]};
    if (wrd)
      s_d.alb_wday = reg_wdata_i[6:0];
    if (wre)
    begin
      s_d.ala_en  = reg_wdata_i[CTRL1_ALA_EN];
      s_d.alb_en  = reg_wdata_i[CTRL1_ALB_EN];
      s_d.per_sel = reg_wdata_i[2:0];
    end
    if (wrf)
    begin
      s_d.fmt24   = reg_wdata_i[CTRL2_HOUR_FMT];
      s_d.clk_dis = reg_wdata_i[CTRL2_CLK_DIS];
    end

    // --------------------------------------------------------------------
    // flags: writing 0 clears, writing 1 is ignored, a set in the same cycle wins
    // --------------------------------------------------------------------
    if (wrf && !reg_wdata_i[CTRL2_PER_FLAG] && per_level)
      s_d.per_flag = 1'b0;
    if (!per_level)
      s_d.per_flag = 1'b0;
    if (per_hit)
      s_d.per_flag = 1'b1;
    if (wrf && !reg_wdata_i[CTRL2_ALA_FLAG])
      s_d.ala_flag = 1'b0;
    if (ala_hit)
      s_d.ala_flag = 1'b1;
    if (wrf && !reg_wdata_i[CTRL2_ALB_FLAG])
      s_d.alb_flag = 1'b0;
    if (alb_hit)
      s_d.alb_flag = 1'b1;
    if (!s_d.ala_en)
      s_d.ala_flag = 1'b0;
    if (!s_d.alb_en)
      s_d.alb_flag = 1'b0;

    // --------------------------------------------------------------------
    // outputs follow the flags that will stand after this edge
    // --------------------------------------------------------------------
    per_lo = s_d.per_flag || (s_d.per_sel == PER_FIXED_LO);
    s_d.irq_a_n = !(per_lo || s_d.ala_flag);
    s_d.irq_b_n = !s_d.alb_flag;

    // --------------------------------------------------------------------
    // read data, captured every cycle; unused bits and holes read zero
    // --------------------------------------------------------------------
    unique case (reg_addr_i)
      ADDR_SEC:      s_d.rdata = {1'b0, s_q.sec[6:0]};
      ADDR_MIN:      s_d.rdata = {1'b0, s_q.min[6:0]};
      ADDR_HOUR:     s_d.rdata = {2'b00, s_q.hour[5:0]};
      ADDR_WDAY:     s_d.rdata = {5'b00000, s_q.wday};
      ADDR_DAY:      s_d.rdata = {2'b00, s_q.day[5:0]};
      ADDR_MONTH:    s_d.rdata = {3'b000, s_q.month[4:0]};
      ADDR_YEAR:     s_d.rdata = s_q.year;
      ADDR_ALA_MIN:  s_d.rdata = s_q.ala_min;
      ADDR_ALA_HOUR: s_d.rdata = s_q.ala_hour;
      ADDR_ALA_WDAY: s_d.rdata = {1'b0, s_q.ala_wday};
      ADDR_ALB_MIN:  s_d.rdata = s_q.alb_min;
      ADDR_ALB_HOUR: s_d.rdata = s_q.alb_hour;
      ADDR_ALB_WDAY: s_d.rdata = {1'b0, s_q.alb_wday};
      ADDR_CTRL1:    s_d.rdata = {s_q.ala_en, s_q.alb_en, 3'b000, s_q.per_sel};
      ADDR_CTRL2:    s_d.rdata = {2'b00, s_q.fmt24, 1'b0, s_q.clk_dis,
                                  !s_q.irq_a_n && (s_q.per_flag || (s_q.per_sel == PER_FIXED_LO)),
                                  s_q.ala_flag, s_q.alb_flag};
      default:       s_d.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // system domain registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.hour    <= RST_HOUR;
      s_q.day     <= RST_ONE;
      s_q.month   <= RST_ONE;
      s_q.year    <= RST_ZERO;
      s_q.irq_a_n <= 1'b1;
      s_q.irq_b_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end
endmodule : rtcc_core
`default_nettype wire

/* dv/rtcc_core_assertions.sv */
`default_nettype none
module rtcc_core_assertions
  import rtcc_pkg::*;
(
  // clocks and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       xtal_clk_i,
  // register port and outputs
  input wire logic [3:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       irq_out_a_n_o,
  input wire logic       irq_out_b_n_o,
  input wire logic       clk_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // shadow of control writes
  // --------
  logic       dis_q;
  logic [2:0] sel_q;
  logic [4:0] cnt_q;
  logic       wc2;

  assign wc2 = reg_wr_i && reg_addr_i == ADDR_CTRL2;

  // counts settle time after disabling, the output lags by a few crystal cycles
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dis_q <= 1'b0;
      sel_q <= 3'h0;
      cnt_q <= 5'h00;
    end
    else
    begin
      if (wc2)
        dis_q <= reg_wdata_i[CTRL2_CLK_DIS];
      if (reg_wr_i && reg_addr_i == ADDR_CTRL1)
        sel_q <= reg_wdata_i[2:0];
      cnt_q <= (wc2 || !dis_q) ? 5'h00 : cnt_q + 5'(cnt_q != 5'h1F);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // --------
  // checks
  // --------
  chk_sec_msb: assert property (reg_addr_i <= ADDR_MIN |=> !reg_rdata_o[7])
    else $error("seconds or minutes bit 7 set");
  chk_sec_bcd: assert property (reg_addr_i == ADDR_SEC |=>
    reg_rdata_o[6:4] <= 3'h5 && reg_rdata_o[3:0] <= 4'h9)
    else $error("seconds not bcd 00 to 59");
  chk_hour_top: assert property (reg_addr_i == ADDR_HOUR |=> reg_rdata_o[7:6] == 2'h0)
    else $error("hours upper bits set");
  chk_wday_code: assert property (reg_addr_i == ADDR_WDAY |=>
    reg_rdata_o[7:3] == 5'h00 && reg_rdata_o[2:0] != 3'h7)
    else $error("weekday read bad");
  chk_day_top: assert property (reg_addr_i == ADDR_DAY |=> reg_rdata_o[7:6] == 2'h0)
    else $error("day upper bits set");
  chk_month_top: assert property (reg_addr_i == ADDR_MONTH |=> reg_rdata_o[7:5] == 3'h0)
    else $error("month upper bits set");
  chk_alarm_keep: assert property (wc2 && reg_wdata_i[CTRL2_ALB_FLAG] && !irq_out_b_n_o
    |=> !irq_out_b_n_o [*2])
    else $error("alarm b released by write of 1");
  chk_alarm_clear: assert property (wc2 && !reg_wdata_i[CTRL2_ALB_FLAG] && !irq_out_b_n_o
    |-> ##[1:3] irq_out_b_n_o)
    else $error("alarm b not released");
  chk_per_clear: assert property (wc2 && !reg_wdata_i[CTRL2_PER_FLAG] && sel_q[2]
    && !reg_wdata_i[CTRL2_ALA_FLAG] && !irq_out_a_n_o |-> ##[1:3] irq_out_a_n_o)
    else $error("periodic output not released");
  chk_clk_off: assert property (dis_q && cnt_q == 5'h1F |-> clk_out_o)
    else $error("clock output runs while disabled");

  cover property ($fell(irq_out_a_n_o));
  cover property (!irq_out_b_n_o);
  cover property (cnt_q == 5'h1F);
endmodule : rtcc_core_assertions

bind rtcc_core rtcc_core_assertions i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .xtal_clk_i(xtal_clk_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .irq_out_a_n_o(irq_out_a_n_o), .irq_out_b_n_o(irq_out_b_n_o), .clk_out_o(clk_out_o));
`default_nettype wire

/* dv/rtcc_host_model.sv */
`default_nettype none
module rtcc_host_model
  import rtcc_pkg::*;
(
  // bus clock and read data
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  // register requests
  output var  logic [3:0] addr_o,
  output var  logic       wr_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    addr_o  = 4'h0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // one byte per strobe, strobe dropped for a cycle between writes
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = (a == ADDR_WDAY && &d[2:0]) ? 8'h00 : d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
  endtask : put

  // read data is registered, so it is taken one edge later
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    @(negedge clk_i);
    d = rdata_i;
  endtask : get
endmodule : rtcc_host_model
`default_nettype wire

/* dv/test_rtcc_time_calendar_counter.sv */
`default_nettype none
module test_rtcc_time_calendar_counter;
  timeunit 1ns;
  timeprecision 1ns;
  import rtcc_pkg::*;

  typedef struct {logic [7:0] fmt; logic [55:0] ini; logic [55:0] exp;} rtcc_row_s;

  logic       clk, rst, xclk, wr, irq_a_n, irq_b_n, clk_out;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  int         miscompares = 0;
  int         n_tests = 0;

  // --------
  // sec min hour wday day month year, before and after one tick
  // --------
  rtcc_row_s rows [12] = '{
    '{8'h20, 56'h59592306311299, 56'h00000000010100},
    '{8'h20, 56'h59592300280201, 56'h00000001010301},
    '{8'h20, 56'h59592302280204, 56'h00000003290204},
    '{8'h20, 56'h59592303290296, 56'h00000004010396},
    '{8'h20, 56'h59592304300410, 56'h00000005010510},
    '{8'h20, 56'h59592305300110, 56'h00000006310110},
    '{8'h20, 56'h59592301301111, 56'h00000002011211},
    '{8'h00, 56'h59593102050620, 56'h00001203060620},
    '{8'h00, 56'h59591102050620, 56'h00003202050620},
    '{8'h00, 56'h59591202050620, 56'h00000102050620},
    '{8'h20, 56'hB085D0F3C5E407, 56'h31051003050407},
    '{8'h20, 56'h58590900150821, 56'h59590900150821}};

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    xclk = 1'b0;
    #37;
    forever #80 xclk = ~xclk;
  end

  rtcc_core #(.XTAL_DIV(32)) i_dut (
    .clk_i(clk), .rst_i(rst), .xtal_clk_i(xclk), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_out_a_n_o(irq_a_n),
    .irq_out_b_n_o(irq_b_n), .clk_out_o(clk_out));
  rtcc_host_model i_host (
    .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // waits for the once-a-second fall; work after it is clear of the next tick
  task automatic tick_wait();
    int n;
    n = 0;
    while (irq_a_n !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    check({7'h00, irq_a_n}, 8'h00);
  endtask : tick_wait

  // format first, so the hour is written in the right coding
  task automatic load(input rtcc_row_s r);
    i_host.put(ADDR_CTRL2, r.fmt);
    for (int k = 0; k < 7; k++)
      i_host.put(4'(k), r.ini[55 - 8 * k -: 8]);
  endtask : load

  task automatic edges(output int e);
    logic p;
    e = 0;
    p = clk_out;
    repeat (40)
    begin
      @(negedge clk);
      e += int'(clk_out !== p);
      p = clk_out;
    end
  endtask : edges

  initial
  begin
    #3000000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    int e;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    i_host.put(ADDR_CTRL1, {5'h00, PER_SECOND});
    tick_wait();
    foreach (rows[i])
    begin
      load(rows[i]);
      tick_wait();
      for (int k = 0; k < 7; k++)
      begin
        i_host.get(4'(k), v);
        check(v, rows[i].exp[55 - 8 * k -: 8]);
      end
      i_host.get(ADDR_CTRL2, v);
      check(v & 8'h24, rows[i].fmt | 8'h04);
    end
    i_host.put(ADDR_CTRL2, 8'h24);
    repeat (2) @(negedge clk);
    check({7'h00, irq_a_n}, 8'h00);
    i_host.put(ADDR_CTRL2, 8'h20);
    repeat (2) @(negedge clk);
    check({7'h00, irq_a_n}, 8'h01);
    // both alarms match midnight of weekday 0, only b is enabled
    tick_wait();
    i_host.put(ADDR_CTRL1, 8'h44);
    for (int k = 0; k < 6; k++)
      i_host.put(ADDR_ALA_MIN + 4'(k), (k % 3 == 2) ? 8'h01 : 8'h00);
    load(rows[0]);
    tick_wait();
    check({7'h00, irq_b_n}, 8'h00);
    i_host.get(ADDR_CTRL2, v);
    check(v & 8'h03, 8'h01);
    i_host.put(ADDR_CTRL2, 8'h21);
    repeat (2) @(negedge clk);
    check({6'h00, irq_a_n, irq_b_n}, 8'h02);
    i_host.put(ADDR_CTRL2, 8'h20);
    repeat (2) @(negedge clk);
    check({6'h00, irq_a_n, irq_b_n}, 8'h03);
    // periodic off first, so a tick cannot race the control writes
    i_host.put(ADDR_CTRL1, 8'h00);
    edges(e);
    check(8'(e > 10), 8'h01);
    i_host.put(ADDR_CTRL2, 8'h28);
    repeat (10) @(negedge clk);
    edges(e);
    check(8'(e), 8'h00);
    check({7'h00, clk_out}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check({5'h00, irq_a_n, irq_b_n, clk_out}, 8'h07);
    check(rdata, 8'h00);
    rst = 1'b0;
    for (int k = 0; k < 7; k++)
    begin
      i_host.get(4'(k), v);
      check(v, 8'(56'h00001200010100 >> (48 - 8 * k)));
    end
    wrap_up();
  end
endmodule : test_rtcc_time_calendar_counter
`default_nettype wire
